// ### pkg/flash_regs_pkg.sv
// Package of offsets, fields and timing counts for flash self-program block
package flash_regs_pkg;
    // Register byte addresses (aligned words)
    localparam logic [7:0] ADDR_CONTROL   = 8'h00;
    localparam logic [7:0] ADDR_UNLOCK    = 8'h04;
    localparam logic [7:0] ADDR_ADR_LOW   = 8'h08;
    localparam logic [7:0] ADDR_ADR_HIGH  = 8'h0c;
    localparam logic [7:0] ADDR_DAT_LOW   = 8'h10;
    localparam logic [7:0] ADDR_DAT_HIGH  = 8'h14;
    localparam logic [7:0] ADDR_PROTECT   = 8'h18;
    localparam logic [7:0] ADDR_SERIAL    = 8'h1c;
    // Control register field positions
    localparam int CTL_RD    = 0;
    localparam int CTL_WR    = 1;
    localparam int CTL_ALLOW      = 2;
    localparam int CTL_FREE       = 4;
    localparam int CTL_LATCH_ONLY = 5;
    localparam int CTL_CFG_SELECT = 6;
    // Unlock key values
    localparam logic [7:0] KEY_FIRST  = 8'h55;
    localparam logic [7:0] KEY_SECOND = 8'haa;
    // Geometry
    localparam int WORD_W  = 14;
    localparam int ADDR_W  = 13;
    localparam int ROW_W   = 5;
    // Operation time, cycles at 50 MHz
    localparam int CLK_MHZ      = 50;
    localparam int PROG_TIME_US = 4;
    localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
    // Unlock progress
    typedef enum logic [1:0] {
        LOCKED   = 2'b00,
        GOT_FIRST = 2'b01,
        UNLOCKED = 2'b10
    } unlock_t;
    // Flash controller states
    typedef enum logic [2:0] {
        IDLE    = 3'b000,
        READ    = 3'b001,
        LATCH   = 3'b010,
        ERASE   = 3'b011,
        PROGRAM = 3'b100
    } op_state_t;
    // Memory port bundle
    typedef struct packed {
        logic              wr;
        logic [ADDR_W-1:0] addr;
        logic [WORD_W-1:0] wdata;
    } mem_req_t;
endpackage

// ### hdl/flash_array.sv
// Program flash storage with registered read data
module flash_array
    import flash_regs_pkg::*;
#(
    parameter int DEPTH = 8192
) (
    // Clock
    input  wire logic              hclk,
    // Access port
    input  wire mem_req_t          req,
    output logic      [WORD_W-1:0] rdata
);
    // Depth must fit the word address
    if (DEPTH < 1 || DEPTH > (1 << ADDR_W)) begin
        $error("depth out of range");
    end
    // Storage words
    logic [WORD_W-1:0] mem [DEPTH];
    // Write and registered read
    always_ff @(posedge hclk) begin
        if (req.wr) begin
            mem[req.addr] <= req.wdata;
        end
        rdata <= mem[req.addr];
    end
endmodule

// ### hdl/row_latches.sv
// Thirty-two word write latch buffer for one flash row
module row_latches
    import flash_regs_pkg::*;
(
    // Clock
    input  wire logic              hclk,
    // Load port
    input  wire logic              load,
    input  wire logic [ROW_W-1:0]  load_idx,
    input  wire logic [WORD_W-1:0] load_data,
    // Drain port
    input  wire logic [ROW_W-1:0]  read_idx,
    output logic      [WORD_W-1:0] read_data
);
    // Latch words
    logic [WORD_W-1:0] lat [1 << ROW_W];
    // Load and registered drain
    always_ff @(posedge hclk) begin
        if (load) begin
            lat[load_idx] <= load_data;
        end
        // Same-cycle load of the drained word passes straight through
        if (load && load_idx == read_idx) begin
            read_data <= load_data;
        end else begin
            read_data <= lat[read_idx];
        end
    end
endmodule

// ### hdl/flash_self_program_regs.sv
// Flash self-program register block on an AHB-Lite slave
//
// The AHB-Lite register port and the address map are this design's own decisions.
module flash_self_program_regs
    import flash_regs_pkg::*;
#(
    parameter int DEPTH       = 8192,
    parameter int PROG_CYCLES_P = PROG_CYCLES
) (
    // Clock and reset
    input  wire logic              hclk,
    input  wire logic              hresetn,
    // AHB-Lite slave
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    // Instruction fetch port
    input  wire logic [ADDR_W-1:0] fetch_addr,
    output logic      [WORD_W-1:0] fetch_data,
    // Busy flag toward the core
    output logic                   busy
);
    // A row walk needs one cycle per word; the timer is 16 bits
    if (PROG_CYCLES_P < (1 << ROW_W) || PROG_CYCLES_P > 65535) begin
        $error("bad program time");
    end

    // Captured address phase
    logic       ph_valid;
    logic       ph_write;
    logic [7:0] ph_addr;
    // Software registers
    logic       config_space_select;
    logic       latch_only_load;
    logic       free;
    logic       program_erase_allow;
    logic       wr;
    logic       rd;
    logic [7:0] adr_low;
    logic [4:0] adr_high;
    logic [7:0] dat_low;
    logic [5:0] dat_high;
    logic       protect_on;
    logic       serial_mode;
    unlock_t    unlock;
    op_state_t  state;
    logic [15:0] timer;
    logic [ROW_W:0] row_idx;
    logic       read_wait;
    // Memory wiring
    mem_req_t          mreq;
    logic [WORD_W-1:0] mrdata;
    logic [WORD_W-1:0] lat_rdata;
    logic [ADDR_W-1:0] full_addr;
    logic              wr_write;
    logic              blocked;
    logic              latch_load;   // Word into the row latches
    logic [ROW_W-1:0]  lat_read_idx; // Latch word drained next

    // Address formed from pair
    assign full_addr = {adr_high, adr_low};
    // Write to the start control bit
    assign wr_write  = ph_valid && ph_write && ph_addr == ADDR_CONTROL
                       && hwdata[CTL_WR];
    // Serial mode may not start an erase or program while protection is on; reads still run
    assign blocked   = serial_mode && protect_on;
    // Load on latch-only, or the last word just before a commit
    assign latch_load = state == LATCH
                        || (state == IDLE && wr && !rd && !free
                            && !latch_only_load);
    // Drain starts at word 0 so the first commit write is right
    assign lat_read_idx = state == PROGRAM
                          ? row_idx[ROW_W-1:0] + ROW_W'(1) : '0;

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign busy      = state != IDLE;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_valid <= 1'b0;
            ph_write <= 1'b0;
            ph_addr  <= 8'h00;
        end else begin
            ph_valid <= hsel && hready && htrans[1];
            ph_write <= hwrite;
            ph_addr  <= haddr[7:0];
        end
    end

    // Unlock sequence tracker
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            unlock <= LOCKED;
        end else if (ph_valid && ph_write) begin
            if (ph_addr == ADDR_UNLOCK) begin
                if (hwdata[7:0] == KEY_FIRST) begin
                    unlock <= GOT_FIRST;
                end else if (hwdata[7:0] == KEY_SECOND
                             && unlock == GOT_FIRST) begin
                    unlock <= UNLOCKED;
                end else begin
                    unlock <= LOCKED;
                end
            end else begin
                // Any other write, start or not, spends the unlock
                unlock <= LOCKED;
            end
        end
    end

    // Control register bits
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            config_space_select <= 1'b0;
            latch_only_load     <= 1'b0;
            free                <= 1'b0;
            program_erase_allow <= 1'b0;
        end else begin
            if (ph_valid && ph_write && ph_addr == ADDR_CONTROL) begin
                config_space_select <= hwdata[CTL_CFG_SELECT];
                latch_only_load     <= hwdata[CTL_LATCH_ONLY];
                program_erase_allow <= hwdata[CTL_ALLOW];
            end
            // Erase select cleared when erase ends, set wins
            if (ph_valid && ph_write && ph_addr == ADDR_CONTROL) begin
                free <= hwdata[CTL_FREE];
            end else if (state == ERASE && timer == 16'd1) begin
                free <= 1'b0;
            end
        end
    end

    // Start bits: software sets, hardware clears
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr <= 1'b0;
            rd <= 1'b0;
        end else begin
            if (wr_write && unlock == UNLOCKED && program_erase_allow
                && !wr && !blocked) begin
                wr <= 1'b1;
            end else if (state == LATCH || (timer == 16'd1
                         && (state == ERASE || state == PROGRAM))) begin
                wr <= 1'b0;
            end
            if (ph_valid && ph_write && ph_addr == ADDR_CONTROL
                && hwdata[CTL_RD] && !rd) begin
                rd <= 1'b1;
            end else if (state == READ && read_wait) begin
                rd <= 1'b0;
            end
        end
    end

    // Address, protection and mode registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            adr_low     <= 8'h00;
            adr_high    <= 5'h00;
            protect_on  <= 1'b0;
            serial_mode <= 1'b0;
        end else if (ph_valid && ph_write && state == IDLE) begin
            unique case (ph_addr)
                ADDR_ADR_LOW:  adr_low     <= hwdata[7:0];
                ADDR_ADR_HIGH: adr_high    <= hwdata[4:0];
                ADDR_PROTECT:  protect_on  <= hwdata[0];
                ADDR_SERIAL:   serial_mode <= hwdata[0];
                default: ;
            endcase
        end
    end

    // Data pair: software writes, read command loads
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dat_low  <= 8'h00;
            dat_high <= 6'h00;
        end else if (state == READ && read_wait) begin
            dat_low  <= mrdata[7:0];
            dat_high <= mrdata[13:8];
        end else if (ph_valid && ph_write) begin
            if (ph_addr == ADDR_DAT_LOW) begin
                dat_low <= hwdata[7:0];
            end
            if (ph_addr == ADDR_DAT_HIGH) begin
                dat_high <= hwdata[5:0];
            end
        end
    end

    // Operation sequencer
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state     <= IDLE;
            timer     <= 16'd0;
            row_idx   <= '0;
            read_wait <= 1'b0;
        end else begin
            unique case (state)
                IDLE: begin
                    read_wait <= 1'b0;
                    if (rd) begin
                        state <= READ;
                    end else if (wr && free) begin
                        state <= ERASE;
                        timer <= 16'(PROG_CYCLES_P);
                        row_idx <= '0;
                    end else if (wr && latch_only_load) begin
                        state <= LATCH;
                    end else if (wr) begin
                        state <= PROGRAM;
                        timer <= 16'(PROG_CYCLES_P);
                        row_idx <= '0;
                    end
                end
                READ: begin
                    read_wait <= 1'b1;
                    if (read_wait) begin
                        state <= IDLE;
                    end
                end
                LATCH: state <= IDLE;
                ERASE, PROGRAM: begin
                    if (!row_idx[ROW_W]) begin
                        row_idx <= row_idx + 1'b1;
                    end
                    if (timer == 16'd1) begin
                        state <= IDLE;
                    end
                    timer <= timer - 16'd1;
                end
                default: state <= IDLE;
            endcase
        end
    end

    // Memory request: erase/program walk the row unless config_space_select is set, else fetch or read
    always_comb begin
        mreq = '0;
        if ((state == ERASE || state == PROGRAM) && !row_idx[ROW_W]
            && !config_space_select) begin
            mreq.wr    = 1'b1;
            mreq.addr  = {full_addr[ADDR_W-1:ROW_W], row_idx[ROW_W-1:0]};
            mreq.wdata = state == ERASE ? '1 : lat_rdata;
        end else if (state == READ) begin
            mreq.addr = full_addr;
        end else begin
            mreq.addr = fetch_addr;
        end
    end
    assign fetch_data = mrdata;

    flash_array #(
        .DEPTH (DEPTH)
    ) u_array (
        .hclk  (hclk),
        .req   (mreq),
        .rdata (mrdata)
    );

    row_latches u_latches (
        .hclk      (hclk),
        .load      (latch_load),
        .load_idx  (full_addr[ROW_W-1:0]),
        .load_data ({dat_high, dat_low}),
        .read_idx  (lat_read_idx),
        .read_data (lat_rdata)
    );

    // Read data mux
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0;
        end else if (hsel && hready && htrans[1] && !hwrite) begin
            unique case (haddr[7:0])
                ADDR_CONTROL:  hrdata <= {24'h0, 1'b1, config_space_select,
                                          latch_only_load, free, 1'b0,
                                          program_erase_allow, wr, rd};
                ADDR_ADR_LOW:  hrdata <= {24'h0, adr_low};
                ADDR_ADR_HIGH: hrdata <= {27'h0, adr_high};
                ADDR_DAT_LOW:  hrdata <= {24'h0, dat_low};
                ADDR_DAT_HIGH: hrdata <= {26'h0, dat_high};
                ADDR_PROTECT:  hrdata <= {31'h0, protect_on};
                ADDR_SERIAL:   hrdata <= {31'h0, serial_mode};
                default:       hrdata <= 32'h0;
            endcase
        end
    end
endmodule

// ### testbench/flash_regs_properties.sv
// Port checks for the flash self-program register block
module flash_regs_properties
    import flash_regs_pkg::*;
#(parameter int PROG_CYCLES_P = PROG_CYCLES) (
    // Bus side
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    // Core side
    input wire logic        busy
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] aq;  // Data-phase address
    logic       rq;  // Data-phase read
    logic       wq;  // Data-phase write
    logic [1:0] key; // Unlock progress
    int         bc;  // Busy run length
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // Track the transfer in data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            aq <= 8'h00;
            rq <= 1'b0;
            wq <= 1'b0;
        end else begin
            aq <= haddr[7:0];
            rq <= hsel && hready && htrans[1] && !hwrite;
            wq <= hsel && hready && htrans[1] && hwrite;
        end
    end
    // Follow the unlock keys and the busy length
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            key <= 2'h0;
            bc  <= 0;
        end else begin
            bc <= busy ? bc + 1 : 0;
            if (wq)
                key <= aq != ADDR_UNLOCK ? 2'h0
                     : hwdata[7:0] == KEY_FIRST ? 2'h1
                     : key == 2'h1 && hwdata[7:0] == KEY_SECOND ? 2'h2
                     : 2'h0;
        end
    end
    property p_zero_wait;
        hreadyout && !hresp;
    endproperty
    a_zero_wait: assert property (p_zero_wait)
        else $error("slave stalled or erred");
    property p_ctl_top;
        rq && aq == ADDR_CONTROL |-> hrdata[7] && !hrdata[3];
    endproperty
    a_ctl_top: assert property (p_ctl_top)
        else $error("control fixed bits wrong");
    property p_dath_zero;
        rq && aq == ADDR_DAT_HIGH |-> hrdata[7:6] == 2'h0;
    endproperty
    a_dath_zero: assert property (p_dath_zero)
        else $error("data high top bits set");
    property p_adrh_zero;
        rq && aq == ADDR_ADR_HIGH |-> hrdata[7:5] == 3'h0;
    endproperty
    a_adrh_zero: assert property (p_adrh_zero)
        else $error("address high top bits set");
    property p_unlock_read;
        rq && aq == ADDR_UNLOCK |-> hrdata == 32'h0;
    endproperty
    a_unlock_read: assert property (p_unlock_read)
        else $error("unlock port read not zero");
    property p_locked;
        wq && aq == ADDR_CONTROL && hwdata[1:0] == 2'h2 && key != 2'h2
            && !busy |=> !busy [*3];
    endproperty
    a_locked: assert property (p_locked)
        else $error("start taken without unlock");
    property p_rd_run;
        wq && aq == ADDR_CONTROL && hwdata[0] && !busy
            |-> ##[1:3] busy ##[1:6] !busy;
    endproperty
    a_rd_run: assert property (p_rd_run)
        else $error("read did not run and end");
    property p_busy_bound;
        bc <= PROG_CYCLES_P + 8;
    endproperty
    a_busy_bound: assert property (p_busy_bound)
        else $error("operation never ended");
endmodule

// ### testbench/core_fetch_model.sv
// Core side model fetching instruction words from program flash
module core_fetch_model
    import flash_regs_pkg::*;
(
    input  wire logic              hclk,
    input  wire logic [ADDR_W-1:0] want,
    output logic      [ADDR_W-1:0] fetch_addr,
    input  wire logic [WORD_W-1:0] fetch_data,
    output logic      [WORD_W-1:0] got
);
    timeunit 1ns;
    timeprecision 1ps;
    // Address out after an edge, fetched word taken back
    always @(posedge hclk) begin
        fetch_addr <= want;
        got        <= fetch_data;
    end
endmodule

// ### testbench/test_flash_self_program_regs.sv
// Self-checking bench for the flash self-program register block
module test_flash_self_program_regs
    import flash_regs_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int PROG_CYCLES_P = 40; // Short operation time
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q;
    logic [1:0] htrans = 2'h0;
    logic hreadyout, hresp, busy;
    logic [ADDR_W-1:0] fetch_addr, want = 13'h0;
    logic [WORD_W-1:0] fetch_data, got, w;
    int err_total = 0;
    int check_count = 0;
    always #10 hclk = ~hclk;
    flash_self_program_regs #(.PROG_CYCLES_P(PROG_CYCLES_P)) dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .fetch_addr(fetch_addr), .fetch_data(fetch_data),
        .busy(busy));
    core_fetch_model core (.hclk(hclk), .want(want),
        .fetch_addr(fetch_addr), .fetch_data(fetch_data), .got(got));
    task automatic chk(input logic [31:0] s, e, input string n);
        check_count++;
        if (s !== e)
            $display("[FAIL] %s expected %h seen %h", n, e, s);
        if (s !== e)
            err_total++;
    endtask
    // One single-word bus transfer
    task automatic xfer(input logic wr, input logic [7:0] a, d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h0, a};
        hwrite <= wr;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask
    task automatic rc(input logic [7:0] a, e, input string n);
        xfer(1'b0, a, 8'h0);
        chk(q, {24'h0, e}, n);
    endtask
    task automatic idle;
        int i;
        i = 0;
        repeat (3) @(posedge hclk);
        while (busy !== 1'b0 && i < 200) begin
            @(posedge hclk);
            i++;
        end
        chk({31'h0, busy}, 32'h0, "busy");
    endtask
    // Set up fields, unlock, then start
    task automatic op(input logic [7:0] c);
        xfer(1'b1, ADDR_CONTROL, c & 8'hfd);
        xfer(1'b1, ADDR_UNLOCK, KEY_FIRST);
        xfer(1'b1, ADDR_UNLOCK, KEY_SECOND);
        xfer(1'b1, ADDR_CONTROL, c);
        idle();
    endtask
    task automatic setw(input logic [12:0] a, input logic [13:0] d);
        xfer(1'b1, ADDR_ADR_HIGH, {3'h0, a[12:8]});
        xfer(1'b1, ADDR_ADR_LOW, a[7:0]);
        xfer(1'b1, ADDR_DAT_LOW, d[7:0]);
        xfer(1'b1, ADDR_DAT_HIGH, {2'h0, d[13:8]});
    endtask
    task automatic rword(input logic [12:0] a, input logic [13:0] e);
        setw(a, 14'h0);
        xfer(1'b1, ADDR_CONTROL, 8'h01);
        idle();
        xfer(1'b0, ADDR_DAT_LOW, 8'h0);
        w[7:0] = q[7:0];
        xfer(1'b0, ADDR_DAT_HIGH, 8'h0);
        w[13:8] = q[5:0];
        chk({18'h0, w}, {18'h0, e}, "word");
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        rc(ADDR_CONTROL, 8'h80, "ctl");
        rc(ADDR_ADR_HIGH, 8'h00, "adrh");
        rc(ADDR_UNLOCK, 8'h00, "unlock");
        setw(13'h1fff, 14'h3fff);
        rc(ADDR_ADR_HIGH, 8'h1f, "adrh");
        rc(ADDR_DAT_HIGH, 8'h3f, "dath");
        xfer(1'b1, ADDR_PROTECT, 8'h01);
        setw(13'h1a43, 14'h0);
        op(8'h16);
        rc(ADDR_CONTROL, 8'h84, "ctl");
        rword(13'h1a5f, 14'h3fff);
        setw(13'h1a44, 14'h0155);
        op(8'h26);
        rword(13'h1a44, 14'h3fff);
        setw(13'h1a43, 14'h02a5);
        op(8'h06);
        rword(13'h1a43, 14'h02a5);
        rword(13'h1a44, 14'h0155);
        want <= 13'h1a43;
        repeat (4) @(posedge hclk);
        chk({18'h0, got}, 32'h2a5, "fetch");
        // Allow and erase set beforehand, so only the keys block
        xfer(1'b1, ADDR_CONTROL, 8'h14);
        xfer(1'b1, ADDR_CONTROL, 8'h16);
        idle();
        rword(13'h1a43, 14'h02a5);
        xfer(1'b1, ADDR_CONTROL, 8'h14);
        xfer(1'b1, ADDR_UNLOCK, KEY_SECOND);
        xfer(1'b1, ADDR_UNLOCK, KEY_FIRST);
        xfer(1'b1, ADDR_CONTROL, 8'h16);
        idle();
        rword(13'h1a43, 14'h02a5);
        // A control write without start spends the unlock
        xfer(1'b1, ADDR_UNLOCK, KEY_FIRST);
        xfer(1'b1, ADDR_UNLOCK, KEY_SECOND);
        xfer(1'b1, ADDR_CONTROL, 8'h14);
        xfer(1'b1, ADDR_CONTROL, 8'h16);
        idle();
        rword(13'h1a43, 14'h02a5);
        op(8'h12);
        rword(13'h1a43, 14'h02a5);
        xfer(1'b1, ADDR_SERIAL, 8'h01);
        op(8'h16);
        rword(13'h1a43, 14'h02a5);
        results();
    end
    initial begin
        repeat (20000) @(posedge hclk);
        err_total++;
        results();
    end
endmodule
bind flash_self_program_regs flash_regs_properties #(
    .PROG_CYCLES_P(PROG_CYCLES_P)) u_props (.hclk(hclk),
    .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
